// ==== inc/flow_ctrl_pkg.sv ====
// Constants, encodings and register map for the program-flow controller.
// Assumes a 32-bit APB register bus and a 16-bit program memory word.
package flow_ctrl_pkg;
  // Widths
  localparam int PC_W = 21;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int SP_W = 5;
  localparam int STACK_DEPTH = 31;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  // Register byte offsets
  localparam logic [7:0] OFF_STACK_PTR = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_PC_LOW = 8'h08;
  localparam logic [7:0] OFF_TBL_PTR = 8'h0C;
  localparam logic [7:0] OFF_TBL_LAT = 8'h10;
  // Field positions
  localparam int FULL_BIT = 7;
  localparam int UNF_BIT = 6;
  localparam int SP_MSB = 4;
  localparam int FAULT_RST_EN_BIT = 0;
  // Reset values
  localparam logic [SP_W-1:0] SP_RST = 5'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic FAULT_RST_EN_RST = 1'b1;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [PC_W-1:0] TBL_PTR_RST = 21'h000000;
  localparam logic [BYTE_W-1:0] TBL_LAT_RST = 8'h00;
  localparam logic [WORD_W-1:0] NOP_WORD = 16'h0000;
  // Counts and steps
  localparam logic [SP_W-1:0] SP_MAX = 5'h1F;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  // Operations presented by the core decoder for the current execute cycle
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_CALL = 4'h1,
    OP_RETURN = 4'h2,
    OP_RETURN_FROM_INTERRUPT = 4'h3,
    OP_BRANCH = 4'h4,
    OP_ADD_W_PCL = 4'h5,
    OP_IRQ = 4'h6,
    OP_TBL_RD = 4'h7,
    OP_TBL_WR = 4'h8,
    OP_PUSH = 4'h9,
    OP_POP = 4'hA
  } core_op_type;
  // Quadrature phases, one-hot
  typedef enum logic [3:0] {
    PH_ONE = 4'h1,
    PH_TWO = 4'h2,
    PH_THREE = 4'h4,
    PH_FOUR = 4'h8
  } phase_type;
endpackage

// ==== src/phase_gen.sv ====
// Quadrature phase generator: divides the core clock by four.
// Assumes pclk is the core oscillator; phases advance on every rising edge.
`timescale 1ns/1ps
`default_nettype none
module phase_gen (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Phase out
  output flow_ctrl_pkg::phase_type phase_r
);
  import flow_ctrl_pkg::*;

  // Ring of four non-overlapping phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= PH_ONE;
    end else begin
      unique case (phase_r)
        PH_ONE: phase_r <= PH_TWO;
        PH_TWO: phase_r <= PH_THREE;
        PH_THREE: phase_r <= PH_FOUR;
        PH_FOUR: phase_r <= PH_ONE;
        default: phase_r <= PH_ONE; // Recover from an illegal code
      endcase
    end
  end

  // Phase four is always followed by phase one
  phase_ring_a: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_r == PH_FOUR) |=> (phase_r == PH_ONE))
    else $error("phase ring broken");
endmodule
`default_nettype wire

// ==== src/cpu_flow_ctrl.sv ====
// Program-flow controller: return stack, fast shadow registers, table
// access, quadrature phases and a two-stage fetch/execute pipeline.
// Assumes the core decoder holds core_op steady for a whole execute cycle
// and that program memory answers prog_addr_r combinationally.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module cpu_flow_ctrl #(
  parameter int DEPTH = flow_ctrl_pkg::STACK_DEPTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [flow_ctrl_pkg::APB_AW-1:0] paddr,
  input wire logic [flow_ctrl_pkg::APB_DW-1:0] pwdata,
  output logic [flow_ctrl_pkg::APB_DW-1:0] prdata_r,
  output logic pready_r,
  output logic pslverr_r,
  // Core decoder requests
  input wire flow_ctrl_pkg::core_op_type core_op,
  input wire logic core_fast,
  input wire logic [flow_ctrl_pkg::PC_W-1:0] branch_target,
  input wire logic [flow_ctrl_pkg::PC_W-1:0] irq_vector,
  input wire logic [flow_ctrl_pkg::BYTE_W-1:0] live_status,
  input wire logic [flow_ctrl_pkg::BYTE_W-1:0] live_working_register,
  input wire logic [flow_ctrl_pkg::BYTE_W-1:0] live_bsr,
  // Shadow restore to the core
  output logic restore_strobe_r,
  output logic [flow_ctrl_pkg::BYTE_W-1:0] restore_status_r,
  output logic [flow_ctrl_pkg::BYTE_W-1:0] restore_working_register_r,
  output logic [flow_ctrl_pkg::BYTE_W-1:0] restore_bsr_r,
  // Program memory
  output logic [flow_ctrl_pkg::PC_W-1:0] prog_addr_r,
  input wire logic [flow_ctrl_pkg::WORD_W-1:0] prog_rdata,
  output logic [flow_ctrl_pkg::BYTE_W-1:0] prog_wdata_r,
  output logic prog_we_r,
  // Pipeline and phase
  output logic [flow_ctrl_pkg::WORD_W-1:0] instruction_register_r,
  output flow_ctrl_pkg::phase_type phase_r,
  output logic stack_fault_reset_r
);
  import flow_ctrl_pkg::*;

  // Program counter, fetch and stack state
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] fetch_addr_r;
  logic [WORD_W-1:0] fetch_latch_r;
  logic flush_r;
  logic [SP_W-1:0] sp_r;
  logic full_r;
  logic unf_r;
  logic fault_rst_en_r;
  logic [PC_W-1:0] stack_mem_r [1:DEPTH];
  logic [BYTE_W-1:0] shadow_status_r;
  logic [BYTE_W-1:0] shadow_working_register_r;
  logic [BYTE_W-1:0] shadow_bsr_r;
  logic [PC_W-1:0] tbl_ptr_r;
  logic [BYTE_W-1:0] tbl_lat_r;

  // Decoded events of this cycle
  logic at_p1;
  logic at_p2;
  logic at_p3;
  logic at_p4;
  logic exec_p4;
  logic do_push;
  logic do_pop;
  logic push_over;
  logic pop_empty;
  logic fault;
  logic [PC_W-1:0] ret_addr;
  logic [BYTE_W-1:0] pcl_sum;
  logic apb_wr;
  logic apb_setup;
  logic [BYTE_W-1:0] sp_reg_view;

  // Does an operation touch the program memory port for a table access
  function automatic logic is_table_op(input core_op_type op);
    return (op == OP_TBL_RD) || (op == OP_TBL_WR);
  endfunction

  // Register decode; also used for the error answer
  function automatic logic is_mapped(input logic [APB_AW-1:0] a);
    return (a == OFF_STACK_PTR) || (a == OFF_CTRL) || (a == OFF_PC_LOW) ||
           (a == OFF_TBL_PTR) || (a == OFF_TBL_LAT);
  endfunction

  phase_gen u_phase_gen (
    .pclk(pclk),
    .presetn(presetn),
    .phase_r(phase_r)
  );

  assign at_p1 = (phase_r == PH_ONE);
  assign at_p2 = (phase_r == PH_TWO);
  assign at_p3 = (phase_r == PH_THREE);
  assign at_p4 = (phase_r == PH_FOUR);
  // While a stack fault reset request is high, the phase-four request is dropped
  assign exec_p4 = at_p4 && !stack_fault_reset_r;
  assign do_push = exec_p4 && ((core_op == OP_CALL) || (core_op == OP_IRQ) || (core_op == OP_PUSH));
  assign do_pop = exec_p4 && ((core_op == OP_RETURN) || (core_op == OP_RETURN_FROM_INTERRUPT) || (core_op == OP_POP));
  assign push_over = do_push && ((sp_r + 5'h01) == SP_MAX || sp_r == SP_MAX);
  assign pop_empty = do_pop && (sp_r == SP_RST);
  assign fault = fault_rst_en_r && (push_over || pop_empty);
  // pc_r has already moved past the flushed fetch slot
  assign ret_addr = pc_r - PC_STEP;
  assign pcl_sum = ret_addr[BYTE_W-1:0] + live_working_register;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready_r && pwrite;
  assign sp_reg_view = {full_r, unf_r, 1'b0, sp_r};

  // Device reset request, one cycle after a stack fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_fault_reset_r <= 1'b0;
    end else begin
      stack_fault_reset_r <= fault;
    end
  end

  // Program counter: step on phase one, redirect at end of execute
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= PC_RST;
      fetch_addr_r <= PC_RST;
      flush_r <= 1'b0;
    end else if (fault) begin
      pc_r <= PC_RST;
      flush_r <= 1'b1;
    end else if (at_p1) begin
      fetch_addr_r <= pc_r;
      pc_r <= pc_r + PC_STEP;
      flush_r <= 1'b0;
    end else if (exec_p4) begin
      flush_r <= 1'b1;
      unique case (core_op)
        OP_CALL, OP_BRANCH: pc_r <= branch_target;
        OP_IRQ: pc_r <= irq_vector;
        OP_RETURN, OP_RETURN_FROM_INTERRUPT: pc_r <= pop_empty ? PC_RST : stack_mem_r[sp_r];
        OP_ADD_W_PCL: pc_r <= {ret_addr[PC_W-1:BYTE_W], pcl_sum[BYTE_W-1:1], 1'b0};
        OP_POP: begin
          // An empty pop vectors to zero like a return does
          if (pop_empty) begin
            pc_r <= PC_RST;
          end else begin
            flush_r <= 1'b0;
          end
        end
        OP_NONE, OP_TBL_RD, OP_TBL_WR, OP_PUSH: flush_r <= 1'b0;
        default: flush_r <= 1'b0; // Undefined op codes change nothing
      endcase
    end
  end

  // Fetch at phase four, load the instruction register at phase one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_latch_r <= NOP_WORD;
      instruction_register_r <= NOP_WORD;
    end else if (at_p4) begin
      fetch_latch_r <= prog_rdata;
    end else if (at_p1) begin
      instruction_register_r <= flush_r ? NOP_WORD : fetch_latch_r;
    end
  end

  // Program memory port: fetch address, borrowed in phase two for a table op
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_addr_r <= PC_RST;
      prog_wdata_r <= TBL_LAT_RST;
      prog_we_r <= 1'b0;
    end else begin
      prog_we_r <= 1'b0;
      if (at_p1) begin
        prog_addr_r <= pc_r;
      end else if (at_p2 && is_table_op(core_op)) begin
        prog_addr_r <= tbl_ptr_r;
        prog_wdata_r <= tbl_lat_r;
        prog_we_r <= (core_op == OP_TBL_WR);
      end else if (at_p3) begin
        prog_addr_r <= fetch_addr_r; // Give the port back before the fetch
      end
    end
  end

  // Table pointer and latch; hardware capture wins over a bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_ptr_r <= TBL_PTR_RST;
      tbl_lat_r <= TBL_LAT_RST;
    end else begin
      if (apb_wr && paddr == OFF_TBL_PTR) begin
        tbl_ptr_r <= pwdata[PC_W-1:0];
      end
      if (at_p3 && core_op == OP_TBL_RD) begin
        tbl_lat_r <= tbl_ptr_r[0] ? prog_rdata[WORD_W-1:BYTE_W] : prog_rdata[BYTE_W-1:0];
      end else if (apb_wr && paddr == OFF_TBL_LAT) begin
        tbl_lat_r <= pwdata[BYTE_W-1:0];
      end
    end
  end

  // Stack pointer and flags; set beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_r <= SP_RST;
      full_r <= FLAG_RST;
      unf_r <= FLAG_RST;
    end else begin
      if (apb_wr && paddr == OFF_STACK_PTR) begin
        sp_r <= pwdata[SP_MSB:0];
        full_r <= full_r & pwdata[FULL_BIT];
        unf_r <= unf_r & pwdata[UNF_BIT];
      end
      if (push_over) begin
        full_r <= 1'b1;
      end
      if (pop_empty) begin
        unf_r <= 1'b1;
      end
      if (fault) begin
        sp_r <= SP_RST;
      end else if (do_push) begin
        sp_r <= (sp_r == SP_MAX) ? SP_MAX : sp_r + 5'h01;
      end else if (do_pop && !pop_empty) begin
        sp_r <= sp_r - 5'h01;
      end
    end
  end

  // Return stack storage; a push at 31 leaves the top entry alone
  genvar gi;
  generate
    for (gi = 1; gi <= DEPTH; gi++) begin : g_stack
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stack_mem_r[gi] <= PC_RST;
        end else if (do_push && sp_r != SP_MAX && (sp_r + 5'h01) == SP_W'(gi)) begin
          stack_mem_r[gi] <= ret_addr;
        end
      end
    end
  endgenerate

  // Fast shadow copies, taken with the interrupt push or a fast call
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_status_r <= 8'h00;
      shadow_working_register_r <= 8'h00;
      shadow_bsr_r <= 8'h00;
    end else if (exec_p4 && (core_op == OP_IRQ || (core_op == OP_CALL && core_fast))) begin
      shadow_status_r <= live_status;
      shadow_working_register_r <= live_working_register;
      shadow_bsr_r <= live_bsr;
    end
  end

  // Restore strobe toward the core on a fast return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restore_strobe_r <= 1'b0;
      restore_status_r <= 8'h00;
      restore_working_register_r <= 8'h00;
      restore_bsr_r <= 8'h00;
    end else begin
      restore_strobe_r <= exec_p4 && core_fast && (core_op == OP_RETURN_FROM_INTERRUPT || core_op == OP_RETURN);
      restore_status_r <= shadow_status_r;
      restore_working_register_r <= shadow_working_register_r;
      restore_bsr_r <= shadow_bsr_r;
    end
  end

  // Configuration bit for fault resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_rst_en_r <= FAULT_RST_EN_RST;
    end else if (apb_wr && paddr == OFF_CTRL) begin
      fault_rst_en_r <= pwdata[FAULT_RST_EN_BIT];
    end
  end

  // APB answer: data prepared in setup, one access cycle, error if unmapped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= apb_setup;
      pslverr_r <= apb_setup && !is_mapped(paddr);
      if (apb_setup) begin
        unique case (paddr)
          OFF_STACK_PTR: prdata_r <= {24'h000000, sp_reg_view};
          OFF_CTRL: prdata_r <= {31'h00000000, fault_rst_en_r};
          OFF_PC_LOW: prdata_r <= {24'h000000, pc_r[BYTE_W-1:0]};
          OFF_TBL_PTR: prdata_r <= {11'h000, tbl_ptr_r};
          OFF_TBL_LAT: prdata_r <= {24'h000000, tbl_lat_r};
          default: prdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  // Checks on the stack and pipeline
  stack_full_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (do_push && sp_r == 5'h1E) |=> full_r)
    else $error("full flag not set on 31st push");
  fault_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (push_over && fault_rst_en_r) |=> (stack_fault_reset_r && sp_r == 5'h00 && full_r))
    else $error("full fault did not reset pointer");
  no_fault_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    !fault_rst_en_r |=> !stack_fault_reset_r)
    else $error("fault reset while disabled");
  saturate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (do_push && sp_r == 5'h1F && !fault_rst_en_r) |=> (sp_r == 5'h1F && $stable(stack_mem_r[31])))
    else $error("pointer did not saturate");
  underflow_a: assert property (@(posedge pclk) disable iff (!presetn)
    pop_empty |=> (unf_r && sp_r == 5'h00 && pc_r == 21'h000000))
    else $error("underflow handling wrong");
  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!full_r && !push_over) |=> !full_r)
    else $error("full flag set without push");
  bit5_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pready_r && paddr == OFF_STACK_PTR && !pwrite) |-> !prdata_r[5])
    else $error("unimplemented bit read one");
  shadow_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_p4 && core_op == OP_IRQ) |=> (shadow_working_register_r == $past(live_working_register) &&
      (sp_r != $past(sp_r) || $past(sp_r) == SP_MAX)))
    else $error("shadow not loaded with push");
  flush_nop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_p4 && core_op == OP_BRANCH) |-> ##2 (instruction_register_r == NOP_WORD))
    else $error("branch did not flush");
  pc_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (at_p1 && !fault) |=> (pc_r == $past(pc_r) + 21'h000002))
    else $error("pc did not step");
  ir_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
    !at_p1 |=> $stable(instruction_register_r))
    else $error("ir changed outside phase one");

  // Scenarios of interest
  cov_full_c: cover property (@(posedge pclk) disable iff (!presetn) push_over);
  cov_unf_c: cover property (@(posedge pclk) disable iff (!presetn) pop_empty);
  cov_restore_c: cover property (@(posedge pclk) disable iff (!presetn) restore_strobe_r);
  cov_table_c: cover property (@(posedge pclk) disable iff (!presetn) prog_we_r);
endmodule
`default_nettype wire

// ==== verif/prog_mem_model.sv ====
// Program memory model: 256 words answered combinationally, byte writes.
// Assumes the controller gives byte addresses and one-cycle write pulses.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  // Clock
  input wire logic pclk,
  // Access from the controller
  input wire logic [flow_ctrl_pkg::PC_W-1:0] prog_addr_r,
  input wire logic [flow_ctrl_pkg::BYTE_W-1:0] prog_wdata_r,
  input wire logic prog_we_r,
  output logic [flow_ctrl_pkg::WORD_W-1:0] prog_rdata
);
  import flow_ctrl_pkg::*;
  logic [WORD_W-1:0] mem [256];
  logic [WORD_W-1:0] junk_r;
  // Recognisable contents, so a wrong fetch shows at once
  initial begin
    junk_r = 16'h5AA5;
    for (int i = 0; i < 256; i++) begin
      mem[i] = {~i[7:0], i[7:0]};
    end
  end
  // Outside the modelled range the word changes every cycle
  always @(posedge pclk) begin
    junk_r <= ~junk_r;
  end
  assign prog_rdata = (prog_addr_r[PC_W-1:9] == '0) ? mem[prog_addr_r[8:1]] : junk_r;
  // One byte per write pulse, half picked by address bit 0
  always @(posedge pclk) begin
    if (prog_we_r === 1'b1) begin
      if (prog_addr_r[0]) begin
        mem[prog_addr_r[8:1]][15:8] <= prog_wdata_r;
      end else begin
        mem[prog_addr_r[8:1]][7:0] <= prog_wdata_r;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the program-flow controller.
// Assumes prog_mem_model stands as program memory; registers sit on APB.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import flow_ctrl_pkg::*;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } row_type;
  logic pclk, presetn, psel, penable, pwrite, core_fast, pready_r, pslverr_r;
  logic restore_strobe_r, prog_we_r, stack_fault_reset_r, er;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata_r, rd;
  core_op_type core_op;
  logic [PC_W-1:0] branch_target, irq_vector, prog_addr_r;
  logic [BYTE_W-1:0] live_status, live_working_register, live_bsr, prog_wdata_r;
  logic [BYTE_W-1:0] restore_status_r, restore_working_register_r, restore_bsr_r;
  logic [WORD_W-1:0] prog_rdata, instruction_register_r;
  phase_type phase_r;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int cnt_rst = 0;
  int cnt_rs = 0;
  int cnt_we = 0;
  row_type rows [13];

  cpu_flow_ctrl u_cpu_flow_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
    .pslverr_r(pslverr_r), .core_op(core_op), .core_fast(core_fast), .branch_target(branch_target),
    .irq_vector(irq_vector), .live_status(live_status), .live_working_register(live_working_register), .live_bsr(live_bsr),
    .restore_strobe_r(restore_strobe_r), .restore_status_r(restore_status_r),
    .restore_working_register_r(restore_working_register_r), .restore_bsr_r(restore_bsr_r), .prog_addr_r(prog_addr_r),
    .prog_rdata(prog_rdata), .prog_wdata_r(prog_wdata_r), .prog_we_r(prog_we_r),
    .instruction_register_r(instruction_register_r), .phase_r(phase_r),
    .stack_fault_reset_r(stack_fault_reset_r));
  prog_mem_model u_prog_mem_model (.pclk(pclk), .prog_addr_r(prog_addr_r), .prog_wdata_r(prog_wdata_r),
    .prog_we_r(prog_we_r), .prog_rdata(prog_rdata));

  // Free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Pulse counters and hang guard; pulses are counted, not timed, to stay latency-neutral
  always @(posedge pclk) begin
    cycles++;
    cnt_rst += (stack_fault_reset_r === 1'b1);
    cnt_rs += (restore_strobe_r === 1'b1);
    cnt_we += (prog_we_r === 1'b1);
    if (cycles == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task tally_and_finish();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  // APB master: request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_r !== 1'b1);
    rd = prdata_r;
    er = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, exp, rd);
  endtask
  // Op presented for one whole instruction cycle; returns at its taking edge
  task exec(input core_op_type op, input logic f);
    do @(posedge pclk); while (phase_r !== PH_FOUR);
    core_op <= op;
    core_fast <= f;
    do @(posedge pclk); while (phase_r !== PH_FOUR);
    core_op <= OP_NONE;
    core_fast <= 1'b0;
  endtask
  task clr();
    cnt_rst = 0;
    cnt_rs = 0;
    cnt_we = 0;
  endtask
  task set_live(input logic [23:0] v);
    {live_status, live_working_register, live_bsr} <= v;
  endtask
  function automatic logic [15:0] word_at(input logic [PC_W-1:0] a);
    return {~a[8:1], a[8:1]};
  endfunction
  // Flushed slot, then target word, then sequential fetch
  task jump_chk(input logic [PC_W-1:0] t);
    @(posedge pclk);
    #1;
    check("fetch addr", 32'(t), 32'(prog_addr_r));
    check("flushed word", 32'(NOP_WORD), 32'(instruction_register_r));
    repeat (4) @(posedge pclk);
    #1;
    check("target word", 32'(word_at(t)), 32'(instruction_register_r));
    check("next addr", 32'(t + PC_STEP), 32'(prog_addr_r));
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, core_fast} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    core_op = OP_NONE;
    branch_target = 21'h000100;
    irq_vector = 21'h000008;
    {live_status, live_working_register, live_bsr} = 24'h0;
    rows = '{'{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h1, 1'b0},
      '{1'b1, 8'h00, 32'hFF, 32'h0, 1'b0}, '{1'b0, 8'h00, 32'h0, 32'h1F, 1'b0},
      '{1'b1, 8'h04, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
      '{1'b1, 8'h0C, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'h1FFFFF, 1'b0},
      '{1'b1, 8'h10, 32'h1A5, 32'h0, 1'b0}, '{1'b0, 8'h10, 32'h0, 32'hA5, 1'b0},
      '{1'b1, 8'h14, 32'h5, 32'h0, 1'b1}, '{1'b0, 8'hFC, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h00, 32'h0, 32'h0, 1'b0}};
    // Look after the first edge, so the reset has surely been applied
    @(posedge pclk);
    #1;
    check("reset phase", 32'(PH_ONE), 32'(phase_r));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Phases rotate one-hot from the first edge after release
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      #1;
      check("phase", 32'(4'h1 << ((i + 1) % 4)), 32'(phase_r));
    end
    // Register table rows: reset values, access kinds, unmapped places
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      check("slverr", 32'(rows[i].e), 32'(er));
      if (!rows[i].wr) check("rdata", rows[i].q, rd);
    end
    // Fault reset off: fill, saturate, no device reset
    clr();
    repeat (30) exec(OP_CALL, 1'b0);
    rd_chk("sp 30", 8'h00, 32'd30);
    exec(OP_CALL, 1'b0);
    rd_chk("full at 31", 8'h00, 32'h9F);
    exec(OP_CALL, 1'b0);
    rd_chk("saturated", 8'h00, 32'h9F);
    check("no fault reset", 32'h0, 32'(cnt_rst));
    // Flags: writing 1 keeps, writing 0 clears, never set by software
    apb(1'b1, 8'h00, 32'hC5);
    rd_chk("flag keep", 8'h00, 32'h85);
    apb(1'b1, 8'h00, 32'h0);
    rd_chk("flag clear", 8'h00, 32'h0);
    exec(OP_RETURN, 1'b0);
    jump_chk(21'h000000);
    rd_chk("underflow", 8'h00, 32'h40);
    check("no fault reset", 32'h0, 32'(cnt_rst));
    // Fault reset on: full and underflow each request one device reset
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h00, 32'h1E);
    clr();
    exec(OP_CALL, 1'b0);
    rd_chk("full reset", 8'h00, 32'h80);
    check("fault pulse", 32'h1, 32'(cnt_rst));
    apb(1'b1, 8'h00, 32'h0);
    clr();
    exec(OP_POP, 1'b0);
    rd_chk("unf reset", 8'h00, 32'h40);
    check("fault pulse", 32'h1, 32'(cnt_rst));
    // Mid-run power-on reset clears the flags
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("por flags", 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h0);
    // Live values change at the taking edge, so shadows must catch the old ones
    set_live(24'h112233);
    exec(OP_IRQ, 1'b0);
    set_live(24'h445566);
    exec(OP_IRQ, 1'b0);
    set_live(24'h778899);
    clr();
    exec(OP_RETURN_FROM_INTERRUPT, 1'b1);
    repeat (3) @(posedge pclk);
    check("irq shadow", 32'h445566, {8'h00, restore_status_r, restore_working_register_r, restore_bsr_r});
    check("restore", 32'h1, 32'(cnt_rs));
    set_live(24'hAABBCC);
    exec(OP_CALL, 1'b1);
    set_live(24'hDDEEFF);
    clr();
    exec(OP_RETURN, 1'b1);
    repeat (3) @(posedge pclk);
    check("call shadow", 32'hAABBCC, {8'h00, restore_status_r, restore_working_register_r, restore_bsr_r});
    check("restore", 32'h1, 32'(cnt_rs));
    clr();
    exec(OP_RETURN, 1'b0);
    repeat (3) @(posedge pclk);
    check("plain return", 32'h0, 32'(cnt_rs));
    // Branch flush, then a computed jump from the word after the target
    exec(OP_BRANCH, 1'b0);
    jump_chk(21'h000100);
    live_working_register <= 8'h06;
    exec(OP_ADD_W_PCL, 1'b0);
    jump_chk(21'h00010A);
    // Table write to an odd byte, then read both halves back
    apb(1'b1, 8'h0C, 32'h21);
    apb(1'b1, 8'h10, 32'h3C);
    clr();
    exec(OP_TBL_WR, 1'b0);
    apb(1'b1, 8'h10, 32'h0);
    check("write pulses", 32'h1, 32'(cnt_we));
    exec(OP_TBL_RD, 1'b0);
    rd_chk("latch high", 8'h10, 32'h3C);
    apb(1'b1, 8'h0C, 32'h20);
    exec(OP_TBL_RD, 1'b0);
    rd_chk("latch low", 8'h10, 32'h10);
    tally_and_finish();
  end
endmodule
`default_nettype wire
